// ===== gpc_pkg.sv
// Constants, register map and carrier types for the general-purpose port block.
// Assumes the processor I/O access is synchronous to core_clk.
package gpc_pkg;

    localparam int PORT_W   = 8;
    localparam int NPORT    = 3;
    localparam int PIN_W    = PORT_W * NPORT;
    localparam int NBANK    = 3;
    localparam int MID_W    = 7;
    localparam int SYNC_LEN = 2;

    // Change-flag bit positions
    localparam int FLAG_LOW  = 0;
    localparam int FLAG_MID  = 1;
    localparam int FLAG_HIGH = 2;

    // I/O addresses
    localparam logic [7:0] ADDR_PORT_BASE = 8'h20;
    localparam logic [7:0] PORT_STRIDE    = 8'h03;
    localparam logic [7:0] OFS_IN         = 8'h00;
    localparam logic [7:0] OFS_DIR        = 8'h01;
    localparam logic [7:0] OFS_OUT        = 8'h02;
    localparam logic [7:0] ADDR_FLAGS     = 8'h3b;
    localparam logic [7:0] ADDR_MASK_LOW  = 8'h6b;
    localparam logic [7:0] ADDR_MASK_MID  = 8'h6c;
    localparam logic [7:0] ADDR_MASK_HIGH = 8'h6d;

    // Reset values
    localparam logic [PIN_W-1:0] PORT_RST = 24'h000000;
    localparam logic [7:0]       MASK_RST = 8'h00;
    localparam logic [7:0]       RD_ZERO  = 8'h00;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
        logic       bit_we;
        logic [2:0] bit_sel;
        logic       bit_val;
    } gpc_io_req_t;

    typedef struct packed {
        logic [PIN_W-1:0] en;
        logic [PIN_W-1:0] oe;
        logic [PIN_W-1:0] out;
    } gpc_alt_t;

    typedef struct packed {
        logic [PIN_W-1:0] out;
        logic [PIN_W-1:0] oe_n;
        logic [PIN_W-1:0] pu;
    } gpc_pad_t;

endpackage

// ===== gpc_sync.sv
// Multi-stage flip-flop synchroniser for the pin inputs.
// Assumes d is asynchronous to core_clk; only the last stage is read.
`timescale 1ns/10ps
module gpc_sync #(
    parameter int W      = 24,
    parameter int STAGES = 2
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    typedef struct packed {
        logic [STAGES-1:0][W-1:0] st;
    } gpc_sync_st_t;

    gpc_sync_st_t cur;
    gpc_sync_st_t next_st;

    initial begin
        if (STAGES < 2 || W < 1) begin
            $error("gpc_sync needs at least two stages");
        end
    end

    always_comb begin
        next_st    = cur;
        next_st.st = {cur.st[STAGES-2:0], d};
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_st;
        end
    end

    assign q = cur.st[STAGES-1];
endmodule

// ===== gpc_bank.sv
// One pin-change bank: change detection, sticky flag and vector request.
// Assumes pins are already synchronised to core_clk.
`timescale 1ns/10ps
module gpc_bank #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] pins,
    input  wire logic [W-1:0] mask,
    input  wire logic         bank_en,
    input  wire logic         gie,
    input  wire logic         clr,
    output logic              flag,
    output logic              irq
);
    typedef struct packed {
        logic [W-1:0] prev;
        logic         primed;
        logic         flag;
        logic         irq;
    } gpc_bank_st_t;

    gpc_bank_st_t cur;
    gpc_bank_st_t next_st;
    logic         hit;

    initial begin
        if (W < 1 || W > 8) begin
            $error("gpc_bank width must be 1 to 8");
        end
    end

    always_comb begin
        next_st        = cur;
        next_st.prev   = pins;
        next_st.primed = 1'b1;
        // First cycle after reset only loads prev, so a high pin is no change
        hit = cur.primed & bank_en & (|((pins ^ cur.prev) & mask));
        // Set wins over a clear arriving in the same cycle
        next_st.flag = hit | (cur.flag & ~clr);
        next_st.irq  = next_st.flag & bank_en & gie;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_st;
        end
    end

    assign flag = cur.flag;
    assign irq  = cur.irq;
endmodule

// ===== gpc_port_top.sv
// Three 8-bit general-purpose ports with pin-change interrupt banks.
// Assumes a single-cycle I/O strobe interface from the processor core and
// that bank enables, global interrupt enable and pull-up disable live elsewhere.
`timescale 1ns/10ps
// Contract
// - Three bank change flags in bits 2..0 set on an enabled pin change.
// - Flag, global and bank enable raise the bank vector; running it clears flag.
// - Writing one to a flag bit clears it; zero leaves it.
// - Flag register bits 7..3 always read zero.
// - High-bank mask at 0x6D, eight read/write bits gating per-pin detection.
// - Mid-bank mask at 0x6C, bits 6..0 read/write, bit 7 reads zero.
// - Low-bank mask at 0x6B, eight read/write bits gating per-pin detection.
// - A cleared mask bit blocks that pin's change interrupt; masks reset zero.
// - Single-bit set and clear writes alter only the addressed bit.
// - Each port has output-data, direction and input-pins registers, bit per pin.
// - Input-pins reads only; output-data and direction read and write.
// - Writing one to an input-pins bit inverts the output-data bit.
// - Global pull-up disable turns off every pull-up.
// - Direction one makes a pin output, zero makes it input.
// - Input pin with output-data one gets pull-up; otherwise pull-up off.
// - All pins tri-state during reset, with or without clock.
// - Output pin drives its output-data bit value.
// - Alternate function on some pins leaves the others normal I/O.
// - Toggle acts on output-data regardless of direction.
// - Pin inputs pass a two-stage synchroniser before the input-pins register.
// - Pull-up only while global disable is zero; else high impedance.
module gpc_port_top (
    input  wire logic                       core_clk,
    input  wire logic                       rstn,
    input  wire gpc_pkg::gpc_io_req_t       io_req,
    output logic      [7:0]                 io_rdata,
    input  wire logic [gpc_pkg::PIN_W-1:0]  pad_in,
    output gpc_pkg::gpc_pad_t               pad,
    input  wire gpc_pkg::gpc_alt_t          alt,
    input  wire logic                       global_pullup_disable,
    input  wire logic                       global_int_enable,
    input  wire logic [gpc_pkg::NBANK-1:0]  bank_enable_register,
    input  wire logic [gpc_pkg::NBANK-1:0]  vector_ack,
    output logic      [gpc_pkg::NBANK-1:0]  bank_irq
);
    typedef struct packed {
        logic [gpc_pkg::PIN_W-1:0] dir;
        logic [gpc_pkg::PIN_W-1:0] outr;
        logic [7:0]                mask_low;
        logic [gpc_pkg::MID_W-1:0] mask_mid;
        logic [7:0]                mask_high;
        logic [7:0]                rdata;
        gpc_pkg::gpc_pad_t         pad;
    } gpc_top_st_t;

    gpc_top_st_t                 cur;
    gpc_top_st_t                 next_st;
    logic [gpc_pkg::PIN_W-1:0]   pin_sync;
    logic [gpc_pkg::NBANK-1:0]   flags;
    logic [gpc_pkg::NBANK-1:0]   flag_clr;
    logic [gpc_pkg::NBANK-1:0]   irq_w;
    logic [gpc_pkg::NBANK-1:0][7:0] bank_pins;
    logic [gpc_pkg::NBANK-1:0][7:0] bank_mask;

    initial begin
        if (gpc_pkg::PORT_W != 8 || gpc_pkg::NPORT != 3) begin
            $error("gpc_port_top is built for three 8-bit ports");
        end
    end

    // Two flops give 1 to 2 cycles of input delay in place of latch plus register
    gpc_sync #(
        .W      (gpc_pkg::PIN_W),
        .STAGES (gpc_pkg::SYNC_LEN)
    ) u_sync (
        .core_clk (core_clk),
        .rstn     (rstn),
        .d        (pad_in),
        .q        (pin_sync)
    );

    // Low bank is port 0, mid bank port 1 bits 6..0, high bank port 2
    assign bank_pins[gpc_pkg::FLAG_LOW]  = pin_sync[7:0];
    assign bank_pins[gpc_pkg::FLAG_MID]  = {1'b0, pin_sync[14:8]};
    assign bank_pins[gpc_pkg::FLAG_HIGH] = pin_sync[23:16];
    assign bank_mask[gpc_pkg::FLAG_LOW]  = cur.mask_low;
    assign bank_mask[gpc_pkg::FLAG_MID]  = {1'b0, cur.mask_mid};
    assign bank_mask[gpc_pkg::FLAG_HIGH] = cur.mask_high;

    // Clear by vector run or by a one written to the flag bit
    always_comb begin
        for (int b = 0; b < gpc_pkg::NBANK; b++) begin
            flag_clr[b] = vector_ack[b]
                | (io_req.we && io_req.addr == gpc_pkg::ADDR_FLAGS && io_req.wdata[b])
                | (io_req.bit_we && io_req.addr == gpc_pkg::ADDR_FLAGS
                   && io_req.bit_sel == 3'(b) && io_req.bit_val);
        end
    end

    genvar gb;
    generate
        for (gb = 0; gb < gpc_pkg::NBANK; gb++) begin : g_bank
            gpc_bank #(
                .W (8)
            ) u_bank (
                .core_clk (core_clk),
                .rstn     (rstn),
                .pins     (bank_pins[gb]),
                .mask     (bank_mask[gb]),
                .bank_en  (bank_enable_register[gb]),
                .gie      (global_int_enable),
                .clr      (flag_clr[gb]),
                .flag     (flags[gb]),
                .irq      (irq_w[gb])
            );
        end
    endgenerate

    always_comb begin
        logic [7:0] a_in;
        logic [7:0] a_dir;
        logic [7:0] a_out;
        logic [7:0] bsel;
        int         i;
        a_in    = '0;
        a_dir   = '0;
        a_out   = '0;
        bsel    = '0;
        i       = 0;
        next_st = cur;
        bsel    = 8'h01 << io_req.bit_sel;

        for (int p = 0; p < gpc_pkg::NPORT; p++) begin
            a_in  = 8'(gpc_pkg::ADDR_PORT_BASE + gpc_pkg::PORT_STRIDE * 8'(p))
                    + gpc_pkg::OFS_IN;
            a_dir = a_in - gpc_pkg::OFS_IN + gpc_pkg::OFS_DIR;
            a_out = a_in - gpc_pkg::OFS_IN + gpc_pkg::OFS_OUT;
            // Byte writes; the input-pins address only toggles, never stores
            if (io_req.we) begin
                if (io_req.addr == a_dir) begin
                    next_st.dir[p*8 +: 8] = io_req.wdata;
                end
                if (io_req.addr == a_out) begin
                    next_st.outr[p*8 +: 8] = io_req.wdata;
                end
                if (io_req.addr == a_in) begin
                    next_st.outr[p*8 +: 8] = cur.outr[p*8 +: 8] ^ io_req.wdata;
                end
            end
            // Single-bit writes touch only the selected bit
            if (io_req.bit_we) begin
                if (io_req.addr == a_dir) begin
                    next_st.dir[p*8 +: 8] = io_req.bit_val ? (cur.dir[p*8 +: 8] | bsel)
                                          : (cur.dir[p*8 +: 8] & ~bsel);
                end
                if (io_req.addr == a_out) begin
                    next_st.outr[p*8 +: 8] = io_req.bit_val ? (cur.outr[p*8 +: 8] | bsel)
                                           : (cur.outr[p*8 +: 8] & ~bsel);
                end
                if (io_req.addr == a_in && io_req.bit_val) begin
                    next_st.outr[p*8 +: 8] = cur.outr[p*8 +: 8] ^ bsel;
                end
            end
        end

        if (io_req.we) begin
            unique case (io_req.addr)
                gpc_pkg::ADDR_MASK_LOW:  next_st.mask_low  = io_req.wdata;
                gpc_pkg::ADDR_MASK_MID:  next_st.mask_mid  = io_req.wdata[gpc_pkg::MID_W-1:0];
                gpc_pkg::ADDR_MASK_HIGH: next_st.mask_high = io_req.wdata;
                default:                 next_st.mask_low  = next_st.mask_low;
            endcase
        end
        if (io_req.bit_we) begin
            unique case (io_req.addr)
                gpc_pkg::ADDR_MASK_LOW: begin
                    next_st.mask_low = io_req.bit_val ? (cur.mask_low | bsel)
                                     : (cur.mask_low & ~bsel);
                end
                gpc_pkg::ADDR_MASK_MID: begin
                    next_st.mask_mid = io_req.bit_val ? (cur.mask_mid | bsel[6:0])
                                     : (cur.mask_mid & ~bsel[6:0]);
                end
                gpc_pkg::ADDR_MASK_HIGH: begin
                    next_st.mask_high = io_req.bit_val ? (cur.mask_high | bsel)
                                      : (cur.mask_high & ~bsel);
                end
                default: next_st.mask_low = next_st.mask_low;
            endcase
        end

        // Read data is registered; unmapped addresses return zero
        if (io_req.re) begin
            next_st.rdata = gpc_pkg::RD_ZERO;
            unique case (io_req.addr)
                gpc_pkg::ADDR_FLAGS:     next_st.rdata = {5'h00, flags};
                gpc_pkg::ADDR_MASK_LOW:  next_st.rdata = cur.mask_low;
                gpc_pkg::ADDR_MASK_MID:  next_st.rdata = {1'b0, cur.mask_mid};
                gpc_pkg::ADDR_MASK_HIGH: next_st.rdata = cur.mask_high;
                default: begin
                    for (int p = 0; p < gpc_pkg::NPORT; p++) begin
                        a_in  = 8'(gpc_pkg::ADDR_PORT_BASE + gpc_pkg::PORT_STRIDE * 8'(p))
                                + gpc_pkg::OFS_IN;
                        a_dir = a_in - gpc_pkg::OFS_IN + gpc_pkg::OFS_DIR;
                        a_out = a_in - gpc_pkg::OFS_IN + gpc_pkg::OFS_OUT;
                        if (io_req.addr == a_in) begin
                            next_st.rdata = pin_sync[p*8 +: 8];
                        end
                        if (io_req.addr == a_dir) begin
                            next_st.rdata = cur.dir[p*8 +: 8];
                        end
                        if (io_req.addr == a_out) begin
                            next_st.rdata = cur.outr[p*8 +: 8];
                        end
                    end
                end
            endcase
        end

        // Pad drive from the newly written settings; alternate overrides are per pin
        for (i = 0; i < gpc_pkg::PIN_W; i++) begin
            if (alt.en[i]) begin
                next_st.pad.out[i]  = alt.out[i];
                next_st.pad.oe_n[i] = ~alt.oe[i];
                next_st.pad.pu[i]   = 1'b0;
            end else begin
                next_st.pad.out[i]  = next_st.outr[i];
                next_st.pad.oe_n[i] = ~next_st.dir[i];
                next_st.pad.pu[i]   = ~next_st.dir[i] & next_st.outr[i]
                                      & ~global_pullup_disable;
            end
        end
    end

    // Asynchronous reset tri-states every pad without needing a clock edge
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            cur.dir       <= gpc_pkg::PORT_RST;
            cur.outr      <= gpc_pkg::PORT_RST;
            cur.mask_low  <= gpc_pkg::MASK_RST;
            cur.mask_mid  <= gpc_pkg::MASK_RST[gpc_pkg::MID_W-1:0];
            cur.mask_high <= gpc_pkg::MASK_RST;
            cur.rdata     <= gpc_pkg::RD_ZERO;
            cur.pad.out   <= gpc_pkg::PORT_RST;
            cur.pad.oe_n  <= ~gpc_pkg::PORT_RST;
            cur.pad.pu    <= gpc_pkg::PORT_RST;
        end else begin
            cur <= next_st;
        end
    end

    assign io_rdata = cur.rdata;
    assign pad      = cur.pad;
    assign bank_irq = irq_w;
endmodule

// ===== gpc_port_top_properties.sv
// Port-level checker for the port block, bound to every instance of the top.
// Assumes alternate overrides stay idle and masks are written with byte writes.
`timescale 1ns/10ps
module gpc_port_top_chk (
    input wire logic                      core_clk,
    input wire logic                      rstn,
    input wire gpc_pkg::gpc_io_req_t      io_req,
    input wire logic [7:0]                io_rdata,
    input wire logic [gpc_pkg::PIN_W-1:0] pad_in,
    input wire gpc_pkg::gpc_pad_t         pad,
    input wire gpc_pkg::gpc_alt_t         alt,
    input wire logic                      global_pullup_disable,
    input wire logic                      global_int_enable,
    input wire logic [gpc_pkg::NBANK-1:0] bank_enable_register,
    input wire logic [gpc_pkg::NBANK-1:0] vector_ack,
    input wire logic [gpc_pkg::NBANK-1:0] bank_irq
);
    typedef struct packed {
        logic [7:0] mask_sh;
        logic [7:0] pin_q;
        logic [2:0] quiet;
    } gpc_chk_st_t;
    gpc_chk_st_t st;
    gpc_chk_st_t next_st;
    logic        byte_wr;
    assign byte_wr = io_req.we && !io_req.bit_we;
    // Quiet counts cycles since the low bank pins last moved, so a clear is not
    // judged while a change is still in the synchroniser
    always_comb begin
        next_st = st;
        next_st.pin_q = pad_in[7:0];
        if (pad_in[7:0] != st.pin_q) begin
            next_st.quiet = 3'h0;
        end else if (st.quiet != 3'h7) begin
            next_st.quiet = st.quiet + 3'h1;
        end
        if (byte_wr && io_req.addr == gpc_pkg::ADDR_MASK_LOW) begin
            next_st.mask_sh = io_req.wdata;
        end
    end
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_reset_tri_state: assert property (disable iff (1'b0) !rstn |-> &pad.oe_n)
        else $error("pins driven during reset");
    // Read data and pads stand one edge after the edge that took the access
    a_flag_upper_zero: assert property (
        io_req.re && io_req.addr == gpc_pkg::ADDR_FLAGS |=> io_rdata[7:3] == 5'h00)
        else $error("flag register upper bits not zero");
    a_mid_top_zero: assert property (
        io_req.re && io_req.addr == gpc_pkg::ADDR_MASK_MID |=> !io_rdata[7])
        else $error("mid mask bit 7 not zero");
    a_dir_sets_oe: assert property (
        byte_wr && io_req.addr == 8'h21 |=> pad.oe_n[7:0] == ~$past(io_req.wdata))
        else $error("direction not on pins");
    a_out_drives_pin: assert property (
        byte_wr && io_req.addr == 8'h22
        |=> (pad.out[7:0] & ~pad.oe_n[7:0]) == ($past(io_req.wdata) & ~pad.oe_n[7:0]))
        else $error("driven level differs from output data");
    a_pullup_inputs: assert property (
        alt.en == '0 |-> (pad.pu & ~pad.oe_n) == '0) else $error("pull-up on a driven pin");
    a_pullup_disabled: assert property (
        $past(global_pullup_disable) |-> pad.pu == '0) else $error("pull-up while disabled");
    a_gie_blocks_irq: assert property (
        !global_int_enable && !$past(global_int_enable) |-> bank_irq == 3'h0)
        else $error("vector request without global enable");
    a_change_raises: assert property (
        (((pad_in[7:0] ^ st.pin_q) & st.mask_sh) != 8'h00) && global_int_enable
        && bank_enable_register[0] |-> ##[2:5] bank_irq[0])
        else $error("enabled pin change raised no request");
    a_ack_clears: assert property (
        vector_ack[0] && st.quiet == 3'h7 |=> !bank_irq[0])
        else $error("vector run left request set");
    c_irq_low: cover property ($rose(bank_irq[0]));
    c_pullup_on: cover property (pad.pu != '0);
    c_flag_read: cover property (io_req.re && io_req.addr == gpc_pkg::ADDR_FLAGS);
endmodule
bind gpc_port_top gpc_port_top_chk u_chk (.core_clk, .rstn, .io_req, .io_rdata, .pad_in, .pad,
    .alt, .global_pullup_disable, .global_int_enable, .bank_enable_register, .vector_ack,
    .bank_irq);

// ===== gpc_pin_env.sv
// External circuitry on the port pins: drivers, pull-ups and floating inputs.
// Assumes one clock; a floating pin without pull-up toggles every cycle so it never reads as held.
`timescale 1ns/10ps
module gpc_pin_env (
    input  wire logic              core_clk,
    input  wire gpc_pkg::gpc_pad_t pad,
    input  wire logic [23:0]       ext_en,
    input  wire logic [23:0]       ext_val,
    output logic      [23:0]       level
);
    logic [23:0] drift = '0;
    always_ff @(posedge core_clk) begin
        drift <= ~drift;
    end
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            if (!pad.oe_n[i]) begin
                level[i] = pad.out[i];
            end else if (ext_en[i]) begin
                level[i] = ext_val[i];
            end else begin
                level[i] = pad.pu[i] | drift[i];
            end
        end
    end
endmodule

// ===== tb_gpc_port_top.sv
// Self-checking bench for the port block: register tasks and pin scenarios.
// Assumes the pin model closes the pad loop and alternate overrides stay idle.
`timescale 1ns/10ps
module tb_gpc_port_top;
    logic                 core_clk = 1'b0;
    logic                 rstn = 1'b1;
    gpc_pkg::gpc_io_req_t io_req = '0;
    logic [7:0]           io_rdata;
    logic [23:0]          pad_in;
    logic [23:0]          ext_val = '0;
    gpc_pkg::gpc_pad_t    pad;
    logic                 pu_disable = 1'b0;
    logic                 gie = 1'b1;
    logic [2:0]           bank_en = 3'h7;
    logic [2:0]           ack = 3'h0;
    logic [2:0]           irq;
    int                   num_errors = 0;
    int                   checked = 0;
    always #10 core_clk = ~core_clk;
    gpc_port_top u_dut (.core_clk(core_clk), .rstn(rstn), .io_req(io_req), .io_rdata(io_rdata),
        .pad_in(pad_in), .pad(pad), .alt('0), .global_pullup_disable(pu_disable),
        .global_int_enable(gie), .bank_enable_register(bank_en), .vector_ack(ack), .bank_irq(irq));
    gpc_pin_env u_pins (.core_clk(core_clk), .pad(pad), .ext_en(24'hffffff), .ext_val(ext_val),
        .level(pad_in));
    task automatic report_and_stop;
        if (num_errors == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Kind 0 reads, 1 writes a byte, 2 writes bit d[2:0] with value d[3]
    task automatic acc(input logic [7:0] a, input logic [7:0] d, input int k);
        @(posedge core_clk);
        io_req.addr <= a;
        io_req.wdata <= d;
        io_req.re <= (k == 0);
        io_req.we <= (k == 1);
        io_req.bit_we <= (k == 2);
        io_req.bit_sel <= d[2:0];
        io_req.bit_val <= d[3];
        @(posedge core_clk);
        io_req.re <= 1'b0;
        io_req.we <= 1'b0;
        io_req.bit_we <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        acc(a, d, 1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string nm);
        acc(a, 8'h00, 0);
        #1 chk(nm, 24'(exp), 24'(io_rdata));
    endtask
    task automatic tgl(input int i);
        @(posedge core_clk);
        ext_val[i] <= ~ext_val[i];
    endtask
    task automatic wait_irq(input int b);
        int n;
        n = 0;
        while (irq[b] !== 1'b1 && n < 10) begin
            @(posedge core_clk);
            n++;
        end
        if (irq[b] !== 1'b1) begin
            num_errors++;
            $display("ERROR bank_irq expected 1 seen %b", irq[b]);
            report_and_stop();
        end
    endtask
    initial begin
        // Falling edge after time zero so the asynchronous reset is seen
        rstn <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("oe_n_reset", 24'hffffff, pad.oe_n);
        @(posedge core_clk);
        rstn <= 1'b1;
        rd(8'h6b, 8'h00, "mask_low_rst");
        rd(8'h3b, 8'h00, "flags_rst");
        wr(8'h6b, 8'hff);
        wr(8'h6c, 8'hff);
        wr(8'h6d, 8'hff);
        rd(8'h6b, 8'hff, "mask_low");
        rd(8'h6c, 8'h7f, "mask_mid");
        rd(8'h6d, 8'hff, "mask_high");
        rd(8'h50, 8'h00, "unmapped");
        // Masks back to zero, else the pad writes below would set stray flags
        for (int m = 0; m < 3; m++) begin
            wr(8'(8'h6b + m), 8'h00);
        end
        for (int p = 0; p < 3; p++) begin
            wr(8'(8'h21 + 3 * p), 8'ha5);
            wr(8'(8'h22 + 3 * p), 8'h3c);
            wr(8'(8'h20 + 3 * p), 8'h0f);
            rd(8'(8'h21 + 3 * p), 8'ha5, "dir");
            rd(8'(8'h22 + 3 * p), 8'h33, "out");
            rd(8'(8'h20 + 3 * p), 8'h21, "pins");
            chk("oe_n", 24'h5a, 24'(pad.oe_n[8*p +: 8]));
            chk("pu", 24'h12, 24'(pad.pu[8*p +: 8]));
            chk("out_pad", 24'h33, 24'(pad.out[8*p +: 8]));
        end
        acc(8'h21, 8'h09, 2);
        rd(8'h21, 8'ha7, "dir_bit_set");
        acc(8'h21, 8'h00, 2);
        rd(8'h21, 8'ha6, "dir_bit_clr");
        acc(8'h20, 8'h0c, 2);
        rd(8'h22, 8'h23, "out_bit_toggle");
        pu_disable <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("pu_disabled", 24'h000000, pad.pu);
        pu_disable <= 1'b0;
        repeat (3) @(posedge core_clk);
        chk("pu_restored", 24'h121201, pad.pu);
        for (int b = 0; b < 3; b++) begin
            wr(8'(8'h21 + 3 * b), 8'h00);
            wr(8'(8'h6b + b), 8'h01);
            tgl(8 * b + 1);
            repeat (6) @(posedge core_clk);
            chk("irq_masked", 24'h0, 24'(irq));
            bank_en <= 3'h0;
            tgl(8 * b);
            repeat (6) @(posedge core_clk);
            rd(8'h3b, 8'h00, "flag_no_enable");
            bank_en <= 3'h7;
            gie <= 1'b0;
            tgl(8 * b);
            repeat (6) @(posedge core_clk);
            chk("irq_no_gie", 24'h0, 24'(irq));
            rd(8'h3b, 8'(1 << b), "flag_set");
            wr(8'h3b, 8'h00);
            rd(8'h3b, 8'(1 << b), "flag_zero_wr");
            gie <= 1'b1;
            wait_irq(b);
            wr(8'h3b, 8'(1 << b));
            rd(8'h3b, 8'h00, "flag_one_wr");
            tgl(8 * b);
            wait_irq(b);
            repeat (5) @(posedge core_clk);
            ack <= 3'(1 << b);
            @(posedge core_clk);
            ack <= 3'h0;
            repeat (3) @(posedge core_clk);
            chk("irq_after_ack", 24'h0, 24'(irq));
            rd(8'h3b, 8'h00, "flag_after_ack");
        end
        report_and_stop();
    end
endmodule
